// [inc/sch_pkg.sv]
// constants for the serial controller host port
package sch_pkg;

  // ************************************************************
  // bus offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFF_CMD_A   = 8'h00;
  localparam logic [7:0] OFF_DATA_A  = 8'h04;
  localparam logic [7:0] OFF_CMD_B   = 8'h08;
  localparam logic [7:0] OFF_DATA_B  = 8'h0C;
  localparam logic [7:0] OFF_INT_ACK = 8'h10;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // indirect register indices
  // ************************************************************
  localparam logic [3:0] REG_CMD     = 4'h0;
  localparam logic [3:0] REG_MODE    = 4'h1;
  localparam logic [3:0] REG_VEC     = 4'h2;
  localparam logic [3:0] REG_PEND    = 4'h3;
  localparam logic [3:0] REG_DTR     = 4'h5;
  localparam logic [3:0] REG_DATA    = 4'h8;
  localparam logic [3:0] REG_MASTER  = 4'h9;
  localparam logic [3:0] REG_TC_LO   = 4'hC;
  localparam logic [3:0] REG_TC_HI   = 4'hD;
  localparam logic [3:0] REG_BRG_CTL = 4'hE;
  localparam logic [3:0] REG_EXT_EN  = 4'hF;
  localparam logic [7:0] RST_REG     = 8'h00;

  // ************************************************************
  // command codes in command byte bits 5:3
  // ************************************************************
  localparam int         CMD_LSB        = 3;
  localparam logic [2:0] CMD_POINT_HIGH = 3'h1;
  localparam logic [2:0] CMD_RESET_EXT  = 3'h2;
  localparam logic [2:0] CMD_ARM_FIRST  = 3'h4;
  localparam logic [2:0] CMD_RESET_TXIP = 3'h5;
  localparam logic [2:0] CMD_ERR_RESET  = 3'h6;
  localparam logic [2:0] CMD_RESET_IUS  = 3'h7;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int MODE_EXT_IE   = 0;
  localparam int MODE_TX_IE    = 1;
  localparam int MODE_PAR_SPEC = 2;
  localparam int MODE_RX_LSB   = 3;
  localparam int MODE_DIR_RX   = 5;
  localparam int MODE_FUNC_REQ = 6;
  localparam int MODE_WR_EN    = 7;
  localparam logic [1:0] RXI_FIRST   = 2'h1;
  localparam logic [1:0] RXI_ALL     = 2'h2;
  localparam int MASTER_VIS    = 0;
  localparam int MASTER_MIE    = 3;
  localparam int DTR_BIT       = 7;
  localparam int BRG_EN        = 0;
  localparam int BRG_DTR_REQ   = 2;
  localparam int EXT_ZC        = 1;
  localparam int EXT_DCD       = 3;
  localparam int EXT_SYNC      = 4;
  localparam int EXT_CTS       = 5;
  localparam int EXT_UNDER     = 6;
  localparam int EXT_BRK       = 7;

  // ************************************************************
  // interrupt sources and vector status codes
  // ************************************************************
  localparam int         SRC_RX   = 0;
  localparam int         SRC_TX   = 1;
  localparam int         SRC_EXT  = 2;
  localparam int         N_SRC    = 6;
  localparam int         VEC_LSB  = 1;
  localparam logic [2:0] VC_NONE  = 3'h3;
  localparam logic [2:0] VC_SPEC  = 3'h3;
  localparam logic [2:0] VC_RX    = 3'h2;
  localparam logic [2:0] VC_EXT   = 3'h1;
  localparam logic [2:0] VC_TX    = 3'h0;
  localparam logic [2:0] VC_CHANA = 3'h4;

endpackage : sch_pkg

// [src/sch_host_port.sv]
// host port of a two-channel serial controller: registers, interrupts, block transfer
// Behaviour
// - six sources, A over B, rx-tx-ext
// - tx interrupt when loaded buffer empties
// - rx interrupt: first, all, or special only
// - overrun, framing, end-of-frame, optional parity special
// - special condition differs only in vector status
// - ext interrupt on modem, underrun, zero, break
// - abort or poll end: interrupt at start, end
// - wait/request pin chosen by mode bits
// - request low when ready for dma
// - wait low while a data access is held off, cpu stretched
// - second request shared with terminal ready
// - two channels, own baud generators, shared interrupts
// - vector status via B, plain via A
// - vector and master control shared, pending read via A only, others per channel
// - three-entry eight-bit receive fifo
// - eight-bit transmit buffer feeds shifter
// - data select goes straight to data register
// - pointer in register zero selects next access
// - pointer clears after indirect access
// - data registers also reachable by pointer
// - time constant readable as two bytes
// - modem inputs readable, interrupts software selected
// - pending drives request only with chain enable
// - under service blocks lower sources and chain
// - master enable off blocks every request
`timescale 1ns/10ps

module sch_host_port
  import sch_pkg::*;
#(
  parameter int ADDR_W   = 8,
  parameter int RX_DEPTH = 3
) (
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // axi4-lite write channels
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // axi4-lite read channels
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // receive shifter side, index 0 is channel A
  input  wire logic [1:0]          rx_valid,
  input  wire logic [1:0][7:0]     rx_char,
  input  wire logic [1:0]          rx_framing_err,
  input  wire logic [1:0]          rx_end_of_frame,
  input  wire logic [1:0]          rx_parity_err,
  // transmit shifter side
  output logic [1:0][7:0]          tx_data,
  output logic [1:0]               tx_valid,
  input  wire logic [1:0]          tx_take,
  // modem and line status
  input  wire logic [1:0]          cts_in,
  input  wire logic [1:0]          carrier_detect_in,
  input  wire logic [1:0]          sync_in,
  input  wire logic [1:0]          tx_underrun,
  input  wire logic [1:0]          break_abort,
  input  wire logic [1:0]          end_of_poll_seq,
  // block transfer and baud generator
  output logic [1:0]               wait_req_n,
  output logic [1:0]               dtr_req_n,
  output logic [1:0]               brg_zero,
  // interrupt daisy chain
  input  wire logic                chain_enable_in,
  output logic                     chain_enable_out,
  output logic                     int_n
);

  // ************************************************************
  // parameter check
  // ************************************************************
  if (ADDR_W < 5 || RX_DEPTH < 1 || RX_DEPTH > 3) begin : g_bad_param
    $error("sch_host_port: ADDR_W or RX_DEPTH out of range");
  end

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [1:0][3:0]      ptr;
    logic [1:0][7:0]      mode;
    logic [7:0]           vec;
    logic [7:0]           master;
    logic [1:0]           dtr;
    logic [1:0][15:0]     tc;
    logic [1:0][7:0]      brg_ctl;
    logic [1:0][7:0]      ext_en;
    logic [1:0][15:0]     brg;
    logic [1:0]           zc;
    logic [1:0][7:0]      tx_buf;
    logic [1:0]           tx_full;
    logic [1:0][2:0][7:0] fifo;
    logic [1:0][2:0]      fspec;
    logic [1:0][1:0]      fcnt;
    logic [1:0][3:0]      errs;
    logic [1:0]           first_done;
    logic [1:0]           first_hit;
    logic [1:0][5:0]      prev;
    logic [N_SRC-1:0]     ip;
    logic [N_SRC-1:0]     under_service_flag;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
  } sch_state_type;

  sch_state_type st_ff;
  sch_state_type nxt_st;

  // ************************************************************
  // functions
  // ************************************************************
  // address to {hit, ack, channel, data select}
  function automatic logic [3:0] sch_decode(input logic [ADDR_W-1:0] a);
    logic [3:0] r;
    r = 4'h0;
    if (a == ADDR_W'(OFF_CMD_A))   r = 4'b1000;
    if (a == ADDR_W'(OFF_DATA_A))  r = 4'b1001;
    if (a == ADDR_W'(OFF_CMD_B))   r = 4'b1010;
    if (a == ADDR_W'(OFF_DATA_B))  r = 4'b1011;
    if (a == ADDR_W'(OFF_INT_ACK)) r = 4'b1100;
    return r;
  endfunction

  // internal daisy chain walk: {valid, source index}
  function automatic logic [3:0] sch_grant(input logic [N_SRC-1:0] ip, input logic [N_SRC-1:0] under_service_flag,
                                           input logic global_irq_enable);
    logic [3:0] g;
    logic       blocked;
    g = 4'h0;
    blocked = 1'b0;
    for (int i = 0; i < N_SRC; i++) begin
      if (!blocked && under_service_flag[i]) blocked = 1'b1;
      else if (!blocked && ip[i] && global_irq_enable) begin
        g = {1'b1, 3'(i)};
        blocked = 1'b1;
      end
    end
    return g;
  endfunction

  // mode selects cpu wait function
  function automatic logic sch_wait_mode(input logic [7:0] m);
    return m[MODE_WR_EN] & ~m[MODE_FUNC_REQ];
  endfunction

  // ************************************************************
  // decode, grant and handshakes
  // ************************************************************
  logic [3:0] aw_dec;
  logic [3:0] ar_dec;
  logic [3:0] grant;
  logic       stall_w;
  logic       stall_r;
  logic       aw_go;
  logic       ar_go;
  logic [2:0] vcode;
  logic [7:0] vec_status;
  logic [7:0] pend_byte;

  assign aw_dec = sch_decode(s_axi_awaddr);
  assign ar_dec = sch_decode(s_axi_araddr);
  assign grant  = sch_grant(st_ff.ip, st_ff.under_service_flag, st_ff.master[MASTER_MIE]);

  // cpu wait stretches a data access in the waited direction
  assign stall_w = aw_dec[3] & ~aw_dec[2] & aw_dec[0] & sch_wait_mode(st_ff.mode[aw_dec[1]]) &
                   ~st_ff.mode[aw_dec[1]][MODE_DIR_RX] & st_ff.tx_full[aw_dec[1]];
  assign stall_r = ar_dec[3] & ~ar_dec[2] & ar_dec[0] & sch_wait_mode(st_ff.mode[ar_dec[1]]) &
                   st_ff.mode[ar_dec[1]][MODE_DIR_RX] & (st_ff.fcnt[ar_dec[1]] == 2'h0);

  assign aw_go         = s_axi_awvalid & s_axi_wvalid & ~st_ff.bvalid & ~stall_w;
  assign ar_go         = s_axi_arvalid & ~st_ff.rvalid & ~stall_r & ~aw_go;
  assign s_axi_awready = aw_go;
  assign s_axi_wready  = aw_go;
  assign s_axi_arready = ar_go;

  // vector status: receive source with special head becomes special code
  always_comb begin
    vcode = VC_NONE;
    if (grant[3]) begin
      unique case (3'(grant[2:0] % 3))
        3'(SRC_RX):  vcode = st_ff.fspec[grant[2:0] / 3][0] ? VC_SPEC : VC_RX;
        3'(SRC_TX):  vcode = VC_TX;
        default:     vcode = VC_EXT;
      endcase
      if (grant[2:0] < 3'h3) vcode = vcode | VC_CHANA;
    end
  end

  assign vec_status = {st_ff.vec[7:VEC_LSB+3], vcode, st_ff.vec[VEC_LSB-1:0]};
  assign pend_byte  = {2'b00, st_ff.ip[0], st_ff.ip[1], st_ff.ip[2],
                       st_ff.ip[3], st_ff.ip[4], st_ff.ip[5]};

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [3:0] idx;
    logic       ch;
    logic [7:0] rbyte;
    logic [7:0] wbyte;
    logic [2:0] cmd;
    logic       cleared;
    logic [5:0] cur;
    logic [5:0] chg;
    logic       zc_tick;
    logic       ext_ev;
    logic       spec_in;
    logic [1:0] rxm;
    idx     = 4'h0;
    ch      = 1'b0;
    rbyte   = 8'h00;
    wbyte   = s_axi_wdata[7:0];
    cmd     = wbyte[CMD_LSB+2:CMD_LSB];
    cleared = 1'b0;
    cur     = 6'h00;
    chg     = 6'h00;
    zc_tick = 1'b0;
    ext_ev  = 1'b0;
    spec_in = 1'b0;
    rxm     = 2'h0;
    nxt_st  = st_ff;

    // shifter takes the transmit buffer
    for (int c = 0; c < 2; c++) begin
      if (tx_take[c] && st_ff.tx_full[c]) begin
        nxt_st.tx_full[c] = 1'b0;
        if (st_ff.mode[c][MODE_TX_IE]) nxt_st.ip[3*c+SRC_TX] = 1'b1;
      end
    end

    // response channels retire
    if (st_ff.bvalid && s_axi_bready) nxt_st.bvalid = 1'b0;
    if (st_ff.rvalid && s_axi_rready) nxt_st.rvalid = 1'b0;

    // register write
    if (aw_go) begin
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = (aw_dec[3] && !aw_dec[2]) ? RESP_OKAY : RESP_SLVERR;
      ch  = aw_dec[1];
      idx = aw_dec[0] ? REG_DATA : st_ff.ptr[ch];
      if (aw_dec[3] && !aw_dec[2] && s_axi_wstrb[0]) begin
        unique case (idx)
          REG_CMD: begin
            nxt_st.ptr[ch] = {cmd == CMD_POINT_HIGH, wbyte[2:0]};
            unique case (cmd)
              CMD_RESET_EXT:  nxt_st.ip[3*ch+SRC_EXT] = 1'b0;
              CMD_ARM_FIRST:  nxt_st.first_done[ch] = 1'b0;
              CMD_RESET_TXIP: begin
                // a take in the same cycle sets the bit again: the event wins
                if (!(tx_take[ch] && st_ff.tx_full[ch] && st_ff.mode[ch][MODE_TX_IE]))
                  nxt_st.ip[3*ch+SRC_TX] = 1'b0;
              end
              CMD_ERR_RESET: begin
                nxt_st.errs[ch]     = 4'h0;
                nxt_st.fspec[ch][0] = 1'b0;
              end
              CMD_RESET_IUS: begin
                for (int i = 0; i < N_SRC; i++) begin
                  if (!cleared && st_ff.under_service_flag[i]) begin
                    nxt_st.under_service_flag[i] = 1'b0;
                    cleared = 1'b1;
                  end
                end
              end
              default: ;
            endcase
          end
          REG_MODE:    nxt_st.mode[ch] = wbyte;
          REG_VEC:     nxt_st.vec = wbyte;
          REG_DTR:     nxt_st.dtr[ch] = wbyte[DTR_BIT];
          REG_DATA: begin
            nxt_st.tx_buf[ch]           = wbyte;
            nxt_st.tx_full[ch]          = 1'b1;
            nxt_st.ip[3*ch+SRC_TX]      = 1'b0;
          end
          REG_MASTER:  nxt_st.master = wbyte;
          REG_TC_LO:   nxt_st.tc[ch][7:0] = wbyte;
          REG_TC_HI:   nxt_st.tc[ch][15:8] = wbyte;
          REG_BRG_CTL: nxt_st.brg_ctl[ch] = wbyte;
          REG_EXT_EN:  nxt_st.ext_en[ch] = wbyte;
          default: ;
        endcase
        if (!aw_dec[0] && idx != REG_CMD) nxt_st.ptr[ch] = REG_CMD;
      end
    end

    // register read
    if (ar_go) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = ar_dec[3] ? RESP_OKAY : RESP_SLVERR;
      ch  = ar_dec[1];
      idx = ar_dec[0] ? REG_DATA : st_ff.ptr[ch];
      if (ar_dec[3] && ar_dec[2]) begin
        // acknowledge: take the granted source into service
        rbyte = st_ff.master[MASTER_VIS] ? vec_status : st_ff.vec;
        if (grant[3] && chain_enable_in) nxt_st.under_service_flag[grant[2:0]] = 1'b1;
      end else if (ar_dec[3]) begin
        unique case (idx)
          REG_CMD: rbyte = {break_abort[ch], tx_underrun[ch], cts_in[ch], sync_in[ch],
                            carrier_detect_in[ch], ~st_ff.tx_full[ch], st_ff.zc[ch],
                            st_ff.fcnt[ch] != 2'h0};
          REG_MODE: rbyte = {st_ff.errs[ch], 3'b000, ~st_ff.tx_full[ch]};
          REG_VEC:  rbyte = ch ? vec_status : st_ff.vec;
          REG_PEND: rbyte = ch ? 8'h00 : pend_byte;
          REG_DATA: begin
            rbyte = st_ff.fifo[ch][0];
            if (st_ff.fcnt[ch] != 2'h0) begin
              nxt_st.fifo[ch]      = {8'h00, st_ff.fifo[ch][2:1]};
              nxt_st.fspec[ch]     = {1'b0, st_ff.fspec[ch][2:1]};
              nxt_st.fcnt[ch]      = st_ff.fcnt[ch] - 2'h1;
              nxt_st.first_hit[ch] = 1'b0;
            end
          end
          REG_TC_LO:  rbyte = st_ff.tc[ch][7:0];
          REG_TC_HI:  rbyte = st_ff.tc[ch][15:8];
          REG_EXT_EN: rbyte = st_ff.ext_en[ch];
          default:    rbyte = 8'h00;
        endcase
        if (!ar_dec[0]) nxt_st.ptr[ch] = REG_CMD;
      end
      nxt_st.rdata = {24'h000000, rbyte};
    end

    // per channel hardware events
    for (int c = 0; c < 2; c++) begin
      rxm = st_ff.mode[c][MODE_RX_LSB+1:MODE_RX_LSB];

      // baud generator counts down and reloads on zero
      zc_tick = st_ff.brg_ctl[c][BRG_EN] && (st_ff.brg[c] == 16'h0000);
      if (!st_ff.brg_ctl[c][BRG_EN] || zc_tick) nxt_st.brg[c] = st_ff.tc[c];
      else nxt_st.brg[c] = st_ff.brg[c] - 16'h0001;
      nxt_st.zc[c] = zc_tick;

      // external status transitions
      cur = {end_of_poll_seq[c], break_abort[c], tx_underrun[c], cts_in[c], sync_in[c], carrier_detect_in[c]};
      chg = cur ^ st_ff.prev[c];
      nxt_st.prev[c] = cur;
      ext_ev = (chg[0] & st_ff.ext_en[c][EXT_DCD]) | (chg[1] & st_ff.ext_en[c][EXT_SYNC]) |
               (chg[2] & st_ff.ext_en[c][EXT_CTS]) |
               (cur[3] & ~st_ff.prev[c][3] & st_ff.ext_en[c][EXT_UNDER]) |
               ((chg[4] | chg[5]) & st_ff.ext_en[c][EXT_BRK]) |
               (zc_tick & st_ff.ext_en[c][EXT_ZC]);
      if (ext_ev && st_ff.mode[c][MODE_EXT_IE]) nxt_st.ip[3*c+SRC_EXT] = 1'b1;

      // receive character into the fifo
      spec_in = rx_framing_err[c] | rx_end_of_frame[c] |
                (rx_parity_err[c] & st_ff.mode[c][MODE_PAR_SPEC]);
      if (rx_valid[c]) begin
        if (nxt_st.fcnt[c] == 2'(RX_DEPTH)) begin
          nxt_st.errs[c][1] = 1'b1;
          nxt_st.fspec[c][nxt_st.fcnt[c] - 2'h1] = 1'b1;
        end else begin
          nxt_st.fifo[c][nxt_st.fcnt[c]]  = rx_char[c];
          nxt_st.fspec[c][nxt_st.fcnt[c]] = spec_in;
          nxt_st.fcnt[c] = nxt_st.fcnt[c] + 2'h1;
          nxt_st.errs[c] = nxt_st.errs[c] | {rx_end_of_frame[c], rx_framing_err[c], 1'b0, rx_parity_err[c]};
          if (rxm == RXI_FIRST && !st_ff.first_done[c]) begin
            nxt_st.first_hit[c]  = 1'b1;
            nxt_st.first_done[c] = 1'b1;
          end
        end
      end

      // receive pending follows the selected option
      nxt_st.ip[3*c+SRC_RX] = ((rxm == RXI_ALL) && (nxt_st.fcnt[c] != 2'h0)) |
                              ((rxm == RXI_FIRST) && nxt_st.first_hit[c]) |
                              ((rxm != 2'h0) && (nxt_st.fcnt[c] != 2'h0) && nxt_st.fspec[c][0]);
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign s_axi_bvalid     = st_ff.bvalid;
  assign s_axi_bresp      = st_ff.bresp;
  assign s_axi_rvalid     = st_ff.rvalid;
  assign s_axi_rresp      = st_ff.rresp;
  assign s_axi_rdata      = st_ff.rdata;
  assign tx_data          = st_ff.tx_buf;
  assign tx_valid         = st_ff.tx_full;
  assign brg_zero         = st_ff.zc;
  assign int_n            = ~(grant[3] & chain_enable_in);
  assign chain_enable_out = chain_enable_in & ~(|st_ff.under_service_flag);

  // wait or request line per channel
  always_comb begin
    logic rdy;
    logic held;
    rdy  = 1'b0;
    held = 1'b0;
    for (int c = 0; c < 2; c++) begin
      rdy  = st_ff.mode[c][MODE_DIR_RX] ? (st_ff.fcnt[c] != 2'h0) : ~st_ff.tx_full[c];
      held = (s_axi_awvalid & s_axi_wvalid & stall_w & (aw_dec[1] == 1'(c))) |
             (s_axi_arvalid & stall_r & (ar_dec[1] == 1'(c)));
      if (!st_ff.mode[c][MODE_WR_EN]) wait_req_n[c] = 1'b1;
      else if (st_ff.mode[c][MODE_FUNC_REQ]) wait_req_n[c] = ~rdy;
      else wait_req_n[c] = ~held;
      // second request serves transmit, the first serves the direction chosen by MODE_DIR_RX
      dtr_req_n[c] = st_ff.brg_ctl[c][BRG_DTR_REQ] ? st_ff.tx_full[c] : ~st_ff.dtr[c];
    end
  end

endmodule // sch_host_port

// [tb/sch_host_port_sva.sv]
// checker for the serial controller host port
`timescale 1ns/10ps
module sch_host_port_sva
  import sch_pkg::*;
(
  input wire logic       aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_bvalid,
  input wire logic       s_axi_arvalid, s_axi_arready, s_axi_rvalid, chain_enable_in, chain_enable_out, int_n,
  input wire logic [7:0] s_axi_awaddr, s_axi_araddr,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp, tx_valid, tx_take, wait_req_n, dtr_req_n,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0][7:0] tx_data
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_chain_out: assert property (!chain_enable_in |-> !chain_enable_out)
    else $error("chain enable passed while input low");
  chk_int_chain: assert property (!chain_enable_in |-> int_n)
    else $error("request while chain input low");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid |=> s_axi_bvalid)
    else $error("write not answered");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  chk_ack_write: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr == OFF_INT_ACK
    |=> s_axi_bresp == RESP_SLVERR)
    else $error("write to ack offset accepted");
  chk_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > OFF_INT_ACK
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read accepted");
  chk_tx_hold: assert property (tx_valid[0] && !tx_take[0] && !s_axi_awvalid
    |=> tx_valid[0] && $stable(tx_data[0]))
    else $error("transmit buffer lost");
  chk_reset_idle: assert property ($rose(aresetn) |-> int_n && wait_req_n == 2'h3 && dtr_req_n == 2'h3)
    else $error("outputs active after reset");
endmodule // sch_host_port_sva
bind sch_host_port sch_host_port_sva u_sva (.*);

// [tb/sch_line_model.sv]
// serial line side model: the shifter takes channel A transmit bytes
`timescale 1ns/10ps
module sch_line_model #(parameter int DELAY = 4) (
  input wire logic            aclk, aresetn,
  input wire logic [1:0]      tx_valid,
  input wire logic [1:0][7:0] tx_data,
  output logic [1:0]          tx_take,
  output logic [7:0]          last_tx
);
  int cnt;
  // busy for DELAY+1 cycles, then one take pulse
  always_ff @(posedge aclk) begin
    tx_take <= 2'h0;
    if (!aresetn) begin
      cnt <= 0;
      last_tx <= 8'h00;
    end else if (tx_valid[0] && !tx_take[0]) begin
      cnt <= cnt + 1;
      if (cnt == DELAY) begin
        tx_take[0] <= 1'b1;
        last_tx <= tx_data[0];
        cnt <= 0;
      end
    end
  end
endmodule // sch_line_model

// [tb/sch_host_port_bench.sv]
// self-checking bench for the serial controller host port
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module sch_host_port_bench;
  import sch_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, chain_enable_in = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, chain_enable_out, int_n;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, rv, last_tx;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, rx_valid = '0, rx_framing_err = '0, rx_end_of_frame = '0;
  logic [1:0] rx_parity_err = '0, cts_in = '0, carrier_detect_in = '0, sync_in = '0, tx_underrun = '0;
  logic [1:0] break_abort = '0, end_of_poll_seq = '0, tx_valid, tx_take, wait_req_n, dtr_req_n, brg_zero;
  logic [1:0][7:0] rx_char = '0, tx_data;
  int fail_count = 0, n_tests = 0;
  sch_host_port u_dut (.*);
  sch_line_model u_line (.aclk, .aresetn, .tx_valid, .tx_data, .tx_take, .last_tx);
  initial forever #2.5 aclk = ~aclk;
  // one axi write, master side
  task automatic wr(input logic [7:0] a, d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, 24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do @(posedge aclk); while (!s_axi_awready);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  // one axi read, result in rv and rr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    {rv, rr} = {s_axi_rdata[7:0], s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic [7:0] ptr(input logic [3:0] i);
    return {2'h0, i[3] ? CMD_POINT_HIGH : 3'h0, i[2:0]};
  endfunction
  task automatic wreg(input logic [7:0] c, input logic [3:0] i, input logic [7:0] d);
    wr(c, ptr(i));
    wr(c, d);
  endtask
  task automatic rreg(input logic [7:0] c, input logic [3:0] i);
    wr(c, ptr(i));
    rd(c);
  endtask
  task automatic wint(input logic v);
    for (int i = 0; i < 40 && int_n !== v; i++) @(posedge aclk);
  endtask
  // one character into the channel A receiver
  task automatic send(input logic [7:0] c, input logic f);
    @(posedge aclk);
    {rx_char[0], rx_framing_err[0], rx_valid[0]} <= {c, f, 1'b1};
    @(posedge aclk);
    rx_valid[0] <= 1'b0;
  endtask
  task automatic complete_run;
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #20000;
    fail_count++;
    complete_run;
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_CMD_A); `CHK(rv, 8'h04)
    wreg(OFF_CMD_A, REG_VEC, 8'h5A);
    rd(OFF_CMD_A); `CHK(rv, 8'h04)
    rreg(OFF_CMD_A, REG_VEC); `CHK(rv, 8'h5A)
    rreg(OFF_CMD_B, REG_VEC); `CHK(rv, {4'h5, VC_NONE, 1'b0})
    wreg(OFF_CMD_B, REG_TC_LO, 8'h34);
    wreg(OFF_CMD_B, REG_TC_HI, 8'h12);
    rreg(OFF_CMD_B, REG_TC_LO); `CHK(rv, 8'h34)
    rreg(OFF_CMD_B, REG_TC_HI); `CHK(rv, 8'h12)
    rreg(OFF_CMD_A, REG_TC_LO); `CHK(rv, 8'h00)
    wreg(OFF_CMD_A, REG_MODE, 8'h02);
    wr(OFF_DATA_A, 8'h77);
    wint(1'b0); `CHK(int_n, 1'b1)
    `CHK(last_tx, 8'h77)
    rreg(OFF_CMD_A, REG_PEND); `CHK(rv, 8'h10)
    rreg(OFF_CMD_B, REG_PEND); `CHK(rv, 8'h00)
    wreg(OFF_CMD_A, REG_MASTER, 8'h08);
    wint(1'b0); `CHK(int_n, 1'b0)
    @(posedge aclk) chain_enable_in <= 1'b0;
    @(posedge aclk) `CHK(int_n, 1'b1)
    chain_enable_in <= 1'b1;
    rd(OFF_INT_ACK); `CHK(rv, 8'h5A)
    `CHK(chain_enable_out, 1'b0)
    wr(OFF_CMD_A, {2'h0, CMD_RESET_TXIP, 3'h0});
    wr(OFF_CMD_A, {2'h0, CMD_RESET_IUS, 3'h0});
    `CHK({chain_enable_out, int_n}, 2'h3)
    wreg(OFF_CMD_A, REG_MODE, 8'h1A);
    send(8'hC3, 1'b1);
    wint(1'b0); `CHK(int_n, 1'b0)
    rreg(OFF_CMD_B, REG_VEC); `CHK(rv, {4'h5, VC_SPEC | VC_CHANA, 1'b0})
    rd(OFF_DATA_A); `CHK(rv, 8'hC3)
    wr(OFF_CMD_A, {2'h0, CMD_ERR_RESET, 3'h0});
    send(8'h11, 1'b0);
    wint(1'b0); `CHK(int_n, 1'b1)
    rreg(OFF_CMD_A, REG_DATA); `CHK(rv, 8'h11)
    wr(OFF_INT_ACK, 8'h00);
    rd(8'h14); `CHK(rr, RESP_SLVERR)
    // request mode on transmit: low while the buffer is empty
    wreg(OFF_CMD_A, REG_MODE, 8'hC0); `CHK(wait_req_n, 2'h2)
    wr(OFF_DATA_A, 8'h55); `CHK(wait_req_n, 2'h3)
    // wait mode: a second byte is held off until the first is taken
    wreg(OFF_CMD_A, REG_MODE, 8'h80);
    wr(OFF_DATA_A, 8'h66);
    wr(OFF_DATA_A, 8'h67); `CHK(last_tx, 8'h66)
    wreg(OFF_CMD_B, REG_DTR, 8'h80); `CHK(dtr_req_n, 2'h1)
    // baud generator of channel A with a period of four cycles
    wreg(OFF_CMD_A, REG_TC_LO, 8'h03);
    wreg(OFF_CMD_A, REG_BRG_CTL, 8'h01);
    while (!brg_zero[0]) @(posedge aclk);
    @(posedge aclk) `CHK(brg_zero, 2'h0)
    repeat (3) @(posedge aclk);
    `CHK(brg_zero, 2'h1)
    // every character interrupts, a pop clears the request
    wreg(OFF_CMD_A, REG_MODE, 8'h10);
    send(8'h22, 1'b0);
    wint(1'b0); `CHK(int_n, 1'b0)
    rd(OFF_DATA_A); `CHK(rv, 8'h22)
    `CHK(int_n, 1'b1)
    complete_run;
  end
endmodule // sch_host_port_bench
